// ==== core/osrc_pkg.sv ====
// constants, tables and carrier types for the optical sample rate configuration block
package osrc_pkg;
	// register map
	localparam logic [7:0] OSRC_ADDR_FRONT = 8'h11;
	localparam logic [7:0] OSRC_ADDR_RATE = 8'h12;
	localparam logic [7:0] OSRC_FRONT_RST = 8'h03;
	localparam logic [7:0] OSRC_RATE_RST = 8'h88;
	// field positions
	localparam int OSRC_ACOFF_BIT = 7;
	localparam int OSRC_OFFS_BIT = 6;
	localparam int OSRC_CH2_LSB = 4;
	localparam int OSRC_CH1_LSB = 2;
	localparam int OSRC_TINT_LSB = 0;
	localparam int OSRC_SR_LSB = 3;
	localparam int OSRC_AVE_LSB = 0;
	// rate codes
	localparam logic [4:0] OSRC_SR_LAST = 5'h13;
	localparam logic [4:0] OSRC_SR_DUAL_LO = 5'h06;
	localparam logic [4:0] OSRC_SR_DUAL_HI = 5'h09;
	localparam int OSRC_SR_CODES = 20;
	localparam logic [3:0] OSRC_BURST_DIS = 4'hf;
	// data widths
	localparam int OSRC_DW = 19;
	localparam int OSRC_RW = 20;
	localparam int OSRC_TW = 13;
	localparam logic [OSRC_RW-1:0] OSRC_OFFSET_SINGLE = 20'h02000;
	localparam logic [OSRC_RW-1:0] OSRC_OFFSET_DUAL = 20'h01000;
	// sample period in sampling clock ticks, scales with a 32768 or 32000 hz clock
	localparam logic [OSRC_TW-1:0] OSRC_SR_TICKS [OSRC_SR_CODES] = '{
		13'h051f, 13'h028f, 13'h0186, 13'h0148, 13'h00a4, 13'h0052,
		13'h051f, 13'h028f, 13'h0186, 13'h0148,
		13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0080,
		13'h0040, 13'h0020, 13'h0010, 13'h0008};
	// burst period in ticks for 8, 32, 84 and 256 hz
	localparam logic [OSRC_TW-1:0] OSRC_BURST_TICKS [4] = '{13'h1000, 13'h0400, 13'h0186, 13'h0080};
	// fastest rate code per exposure count (rows 1..6) and integration code
	localparam logic [4:0] OSRC_MAX_SINGLE [6][4] = '{
		'{5'h13, 5'h12, 5'h12, 5'h11}, '{5'h12, 5'h11, 5'h11, 5'h10},
		'{5'h11, 5'h11, 5'h10, 5'h10}, '{5'h11, 5'h10, 5'h10, 5'h05},
		'{5'h10, 5'h10, 5'h10, 5'h0f}, '{5'h10, 5'h10, 5'h05, 5'h0f}};
	localparam logic [4:0] OSRC_MAX_DUAL [6][4] = '{
		'{5'h09, 5'h09, 5'h09, 5'h09}, '{5'h09, 5'h08, 5'h08, 5'h08},
		'{5'h07, 5'h07, 5'h07, 5'h07}, '{5'h06, 5'h06, 5'h06, 5'h06},
		'{5'h06, 5'h06, 5'h06, 5'h06}, '{5'h06, 5'h06, 5'h06, 5'h06}};
	// largest averaging code per burst rate, nibble n is burst rate n
	localparam logic [15:0] OSRC_BURST_MAX [OSRC_SR_CODES] = '{
		16'hfff1, 16'hff02, 16'hff13, 16'hff13, 16'hf024, 16'hf135,
		16'hfff1, 16'hff02, 16'hff13, 16'hff13,
		16'hffff, 16'hfff0, 16'hfff1, 16'hff02, 16'hf013, 16'hf124,
		16'hf235, 16'h0346, 16'h1457, 16'h2567};
	// analog timing in ns
	localparam int OSRC_CLK_NS = 20;
	localparam int OSRC_TINT_NS [4] = '{14800, 29400, 58700, 117300};
	localparam int OSRC_SETTLE_NS [4] = '{4000, 6000, 8000, 12000};
	localparam int OSRC_PW_EXTRA_NS = 500;

	typedef struct packed {
		logic valid;
		logic ch;
		logic [OSRC_DW-1:0] data;
	} osrc_sample_type;

	typedef struct packed {
		logic valid;
		logic ch;
		logic [OSRC_RW-1:0] data;
	} osrc_result_type;
endpackage : osrc_pkg

// ==== core/osrc_average.sv ====
// per-channel averaging and decimation with dark offset
`timescale 1ns/100ps
`default_nettype none
module osrc_average #(
	parameter int CH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic [2:0] ave_sel,
	input wire logic [osrc_pkg::OSRC_RW-1:0] offset,
	input wire osrc_pkg::osrc_sample_type smp,
	output osrc_pkg::osrc_result_type res
);
	import osrc_pkg::*;

	localparam int AW = OSRC_DW + 7;

	typedef struct packed {
		logic [CH-1:0][AW-1:0] acc;
		logic [CH-1:0][6:0] cnt;
		osrc_result_type res;
	} osrc_avg_state_type;

	osrc_avg_state_type s_r, s_nxt;
	logic [AW-1:0] sum;
	logic [AW-1:0] mean;
	logic [6:0] last;

	// accumulate per channel, emit one decimated value per group
	always_comb begin
		s_nxt = s_r;
		s_nxt.res.valid = 1'b0;
		last = 7'((8'h01 << ave_sel) - 8'h01);
		sum = s_r.acc[smp.ch] + AW'(smp.data);
		mean = sum >> ave_sel;
		if (clr) begin
			s_nxt.acc = '0;
			s_nxt.cnt = '0;
		end else if (smp.valid) begin
			if (s_r.cnt[smp.ch] >= last) begin
				s_nxt.acc[smp.ch] = '0;
				s_nxt.cnt[smp.ch] = '0;
				s_nxt.res.valid = 1'b1;
				s_nxt.res.ch = smp.ch;
				s_nxt.res.data = OSRC_RW'(mean[OSRC_DW-1:0]) + offset;
			end else begin
				s_nxt.acc[smp.ch] = sum;
				s_nxt.cnt[smp.ch] = s_r.cnt[smp.ch] + 7'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign res = s_r.res;
endmodule : osrc_average
`default_nettype wire

// ==== core/osrc_config.sv ====
// configuration registers, rate clamping and sample sequencing for the optical readout
//
// Operation
// - dark offset adds 8192 single, 4096 dual
// - two-bit range per channel, 4096..32768 nA
// - integration code picks time; pulse adds settle
// - five-bit rate code selects sample rate
// - timing counts ticks of sampling clock
// - unsupported rate replaced by fastest supported
// - rate readback shows rate in effect
// - fastest rate follows integration and exposures
// - averaging code selects 1 to 128
// - per-channel average, one value per group
// - burst mode: averaging code is burst length
// - burst length clamped to largest fitting
// - burst off if single conversion fails
// - bursts repeat at selected burst rate
// - too slow rate forces continuous mode
// - settle code delays integration start
`timescale 1ns/100ps
`default_nettype none
module osrc_config #(
	parameter int CLK_PERIOD_NS = osrc_pkg::OSRC_CLK_NS,
	parameter int CH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic sclk_pin,
	input wire logic [2:0] exposures_sel,
	input wire logic burst_en_req,
	input wire logic [1:0] burst_rate_sel,
	input wire logic [1:0] led_settle_delay,
	input wire osrc_pkg::osrc_sample_type adc_smp,
	output osrc_pkg::osrc_result_type fifo_res,
	output logic ambient_cancel,
	output logic [1:0] channel1_range,
	output logic [1:0] channel2_range,
	output logic sample_start,
	output logic led_on,
	output logic integrate_on,
	output logic burst_active,
	output logic burst_forced_off
);
	import osrc_pkg::*;

	typedef struct packed {
		logic [7:0] front;
		logic [7:0] rate;
		logic [1:0] sync;
		logic sclk_d;
		logic [OSRC_TW-1:0] tick_cnt;
		logic [OSRC_TW-1:0] burst_cnt;
		logic [7:0] conv_cnt;
		logic [4:0] act_sr;
		logic [2:0] act_ave;
		logic [1:0] act_tint;
		logic [1:0] act_settle;
		logic act_burst;
		logic act_dual;
		logic act_offs;
		logic [1:0] act_brate;
		logic [7:0] rdata;
		logic start;
		logic exp_run;
		logic exp_second;
		logic [OSRC_TW-1:0] exp_cnt;
		logic led;
		logic integ;
	} osrc_state_type;

	osrc_state_type s_r, s_nxt;

	// ns to clock cycles, rounded up, at least one
	function automatic logic [OSRC_TW-1:0] osrc_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (c < 1) begin
			c = 1;
		end
		return OSRC_TW'(c);
	endfunction : osrc_cyc

	// dual-pulse rate codes
	function automatic logic osrc_is_dual(input logic [4:0] sr);
		return (sr >= OSRC_SR_DUAL_LO) && (sr <= OSRC_SR_DUAL_HI);
	endfunction : osrc_is_dual

	logic [4:0] req_sr;
	logic [2:0] req_ave;
	logic [1:0] req_tint;
	logic [2:0] exp_idx;
	logic [4:0] max_sr;
	logic [4:0] eff_sr;
	logic [3:0] burst_cap;
	logic eff_burst;
	logic [2:0] eff_ave;
	logic tick;
	logic boundary;
	logic burst_wrap;
	logic [7:0] burst_len;
	logic [OSRC_TW-1:0] settle_cyc;
	logic [OSRC_TW-1:0] tint_cyc;
	logic [OSRC_TW-1:0] pw_cyc;
	logic avg_clr;
	logic [OSRC_RW-1:0] offset;

	assign req_sr = s_r.rate[OSRC_SR_LSB +: 5];
	assign req_ave = s_r.rate[OSRC_AVE_LSB +: 3];
	assign req_tint = s_r.front[OSRC_TINT_LSB +: 2];

	// rate clamping against the pulse budget
	always_comb begin
		exp_idx = 3'h0;
		if (exposures_sel > 3'h6) begin
			exp_idx = 3'h5;
		end else if (exposures_sel != 3'h0) begin
			exp_idx = exposures_sel - 3'h1;
		end
		if (osrc_is_dual(req_sr)) begin
			max_sr = OSRC_MAX_DUAL[exp_idx][req_tint];
		end else begin
			max_sr = OSRC_MAX_SINGLE[exp_idx][req_tint];
		end
		// reserved codes fall back to the fastest supported rate
		if (req_sr > OSRC_SR_LAST) begin
			eff_sr = max_sr;
		end else if (OSRC_SR_TICKS[req_sr] < OSRC_SR_TICKS[max_sr]) begin
			eff_sr = max_sr;
		end else begin
			eff_sr = req_sr;
		end
	end

	// burst feasibility and burst length clamping
	always_comb begin
		burst_cap = OSRC_BURST_MAX[eff_sr][burst_rate_sel * 4 +: 4];
		eff_burst = burst_en_req && (burst_cap != OSRC_BURST_DIS);
		eff_ave = req_ave;
		if (eff_burst && (3'(burst_cap) < req_ave)) begin
			eff_ave = 3'(burst_cap);
		end
	end

	assign tick = s_r.sync[1] & ~s_r.sclk_d;
	assign boundary = tick && (s_r.tick_cnt >= OSRC_SR_TICKS[s_r.act_sr] - 13'h0001);
	assign burst_wrap = tick && (s_r.burst_cnt >= OSRC_BURST_TICKS[s_r.act_brate] - 13'h0001);
	assign burst_len = 8'(9'h001 << s_r.act_ave);
	assign avg_clr = boundary && ((eff_ave != s_r.act_ave) || (eff_sr != s_r.act_sr));

	// exposure window lengths for the settings in use
	always_comb begin
		settle_cyc = osrc_cyc(OSRC_SETTLE_NS[s_r.act_settle]);
		tint_cyc = osrc_cyc(OSRC_TINT_NS[s_r.act_tint]);
		pw_cyc = osrc_cyc(OSRC_TINT_NS[s_r.act_tint] + OSRC_SETTLE_NS[s_r.act_settle] + OSRC_PW_EXTRA_NS);
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		// register writes
		if (reg_wr && (reg_addr == OSRC_ADDR_FRONT)) begin
			s_nxt.front = reg_wdata;
		end
		if (reg_wr && (reg_addr == OSRC_ADDR_RATE)) begin
			s_nxt.rate = reg_wdata;
		end
		// register reads, unmapped addresses answer zero
		if (reg_rd) begin
			case (reg_addr)
				OSRC_ADDR_FRONT: s_nxt.rdata = s_r.front;
				OSRC_ADDR_RATE: s_nxt.rdata = {eff_sr, req_ave};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		// sampling clock edge detect on the synchronised level
		s_nxt.sync = {s_r.sync[0], sclk_pin};
		s_nxt.sclk_d = s_r.sync[1];
		if (tick) begin
			s_nxt.tick_cnt = s_r.tick_cnt + 13'h0001;
			s_nxt.burst_cnt = s_r.burst_cnt + 13'h0001;
		end
		if (burst_wrap) begin
			s_nxt.burst_cnt = '0;
			s_nxt.conv_cnt = 8'h00;
		end
		if (boundary) begin
			s_nxt.tick_cnt = '0;
			// rate, averaging, timing, burst and offset settings are taken only here so no sample mixes old and new
			s_nxt.act_sr = eff_sr;
			s_nxt.act_ave = eff_ave;
			s_nxt.act_tint = req_tint;
			s_nxt.act_settle = led_settle_delay;
			s_nxt.act_burst = eff_burst;
			s_nxt.act_brate = burst_rate_sel;
			s_nxt.act_dual = osrc_is_dual(eff_sr);
			s_nxt.act_offs = s_r.front[OSRC_OFFS_BIT];
			if (!eff_burst) begin
				s_nxt.start = 1'b1;
				s_nxt.conv_cnt = 8'h00;
			end else if ((s_r.conv_cnt < burst_len) && !burst_wrap) begin
				s_nxt.start = 1'b1;
				s_nxt.conv_cnt = s_r.conv_cnt + 8'h01;
			end
		end
		// led pulse and integration window, repeated for dual-pulse rates
		if (s_r.start) begin
			s_nxt.exp_run = 1'b1;
			s_nxt.exp_second = s_r.act_dual;
			s_nxt.exp_cnt = '0;
		end else if (s_r.exp_run) begin
			s_nxt.exp_cnt = s_r.exp_cnt + 13'h0001;
			if (s_r.exp_cnt >= pw_cyc - 13'h0001) begin
				s_nxt.exp_cnt = '0;
				s_nxt.exp_run = s_r.exp_second;
				s_nxt.exp_second = 1'b0;
			end
		end
		s_nxt.led = s_nxt.exp_run && (s_nxt.exp_cnt < pw_cyc);
		s_nxt.integ = s_nxt.exp_run && (s_nxt.exp_cnt >= settle_cyc)
			&& (s_nxt.exp_cnt < settle_cyc + tint_cyc);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.front <= OSRC_FRONT_RST;
			s_r.rate <= OSRC_RATE_RST;
			s_r.act_sr <= OSRC_RATE_RST[OSRC_SR_LSB +: 5];
			s_r.act_tint <= OSRC_FRONT_RST[OSRC_TINT_LSB +: 2];
		end else begin
			s_r <= s_nxt;
		end
	end

	// offset depends on single or dual pulse rate in use
	assign offset = !s_r.act_offs ? '0 : (s_r.act_dual ? OSRC_OFFSET_DUAL : OSRC_OFFSET_SINGLE);

	osrc_average #(
		.CH(CH)
	) u_average (
		.clk(clk),
		.rst(rst),
		.clr(avg_clr),
		.ave_sel(s_r.act_ave),
		.offset(offset),
		.smp(adc_smp),
		.res(fifo_res)
	);

	// register-driven outputs except burst_forced_off, which gates the burst_en_req input
	assign reg_rdata = s_r.rdata;
	assign ambient_cancel = ~s_r.front[OSRC_ACOFF_BIT];
	assign channel1_range = s_r.front[OSRC_CH1_LSB +: 2];
	assign channel2_range = s_r.front[OSRC_CH2_LSB +: 2];
	assign sample_start = s_r.start;
	assign led_on = s_r.led;
	assign integrate_on = s_r.integ;
	assign burst_active = s_r.act_burst;
	assign burst_forced_off = burst_en_req & ~s_r.act_burst;
endmodule : osrc_config
`default_nettype wire

// ==== verification/osrc_config_monitor.sv ====
// assertion checker for the optical sample rate configuration block
`timescale 1ns/100ps
`default_nettype none
module osrc_config_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic burst_en_req,
	input wire osrc_pkg::osrc_sample_type adc_smp,
	input wire osrc_pkg::osrc_result_type fifo_res,
	input wire logic ambient_cancel,
	input wire logic [1:0] channel1_range,
	input wire logic [1:0] channel2_range,
	input wire logic sample_start,
	input wire logic led_on,
	input wire logic integrate_on,
	input wire logic burst_active,
	input wire logic burst_forced_off
);
	import osrc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// settle delay holds integration off for at least two cycles at the bench clock scaling
	sequence s_settle;
		!integrate_on ##1 !integrate_on;
	endsequence
	// outputs follow the stored field one cycle after the write edge
	property p_front;
		reg_wr && reg_addr == OSRC_ADDR_FRONT |=> (ambient_cancel == !$past(reg_wdata[7])
			&& channel1_range == $past(reg_wdata[3:2]) && channel2_range == $past(reg_wdata[5:4]));
	endproperty
	property p_unmapped;
		reg_rd && reg_addr != OSRC_ADDR_FRONT && reg_addr != OSRC_ADDR_RATE |=> reg_rdata == 8'h00;
	endproperty
	property p_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	property p_start;
		sample_start |=> !sample_start;
	endproperty
	property p_led;
		sample_start |=> led_on;
	endproperty
	property p_inside;
		integrate_on |-> led_on;
	endproperty
	property p_settle;
		$rose(led_on) |-> s_settle;
	endproperty
	property p_fifo;
		fifo_res.valid |-> $past(adc_smp.valid) && fifo_res.ch == $past(adc_smp.ch);
	endproperty
	property p_burst;
		burst_forced_off |-> burst_en_req && !burst_active;
	endproperty
	a_front: assert property (p_front) else $error("front config outputs wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_hold: assert property (p_hold) else $error("read data changed without read");
	a_start: assert property (p_start) else $error("sample start longer than one cycle");
	a_led: assert property (p_led) else $error("led window missing after start");
	a_inside: assert property (p_inside) else $error("integration outside led window");
	a_settle: assert property (p_settle) else $error("integration began before settling");
	a_fifo: assert property (p_fifo) else $error("result without matching sample");
	a_burst: assert property (p_burst) else $error("burst forced off while active");
	c_fifo: cover property (fifo_res.valid);
endmodule : osrc_config_monitor
`default_nettype wire

// ==== verification/tb_optical_sample_rate_config.sv ====
// self-checking testbench for the optical sample rate configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_optical_sample_rate_config;
	import osrc_pkg::*;
	// scaled clock period so led windows stay short against fast ticks
	localparam int P = 2000;
	typedef struct packed {
		logic [7:0] front;
		logic [2:0] expo;
		logic [1:0] settle;
		logic ben;
		logic [1:0] brate;
		logic [7:0] rate_wr;
		logic [7:0] rate_rd;
		logic bact;
		logic meas;
	} osrc_row_type;
	localparam osrc_row_type ROWS [9] = '{
		'{8'h00, 3'h1, 2'h0, 1'b0, 2'h0, 8'h98, 8'h98, 1'b0, 1'b1},
		'{8'h03, 3'h1, 2'h3, 1'b0, 2'h0, 8'h98, 8'h88, 1'b0, 1'b1},
		'{8'hb4, 3'h1, 2'h1, 1'b0, 2'h0, 8'ha7, 8'h9f, 1'b0, 1'b1},
		'{8'h69, 3'h2, 2'h2, 1'b0, 2'h0, 8'h93, 8'h8b, 1'b0, 1'b0},
		'{8'h03, 3'h6, 2'h0, 1'b0, 2'h0, 8'h82, 8'h7a, 1'b0, 1'b0},
		'{8'h03, 3'h4, 2'h0, 1'b0, 2'h0, 8'h2d, 8'h2d, 1'b0, 1'b0},
		'{8'h00, 3'h3, 2'h0, 1'b0, 2'h0, 8'h49, 8'h39, 1'b0, 1'b0},
		'{8'h00, 3'h1, 2'h0, 1'b1, 2'h3, 8'h88, 8'h88, 1'b1, 1'b1},
		'{8'h00, 3'h1, 2'h0, 1'b1, 2'h3, 8'h70, 8'h70, 1'b0, 1'b1}};
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sclk_pin = 1'b0, burst_en_req = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d8;
	logic [2:0] exposures_sel = 3'h1;
	logic [1:0] burst_rate_sel = 2'h0, led_settle_delay = 2'h0, channel1_range, channel2_range;
	osrc_sample_type adc_smp = '0;
	osrc_result_type fifo_res;
	logic ambient_cancel, sample_start, led_on, integrate_on, burst_active, burst_forced_off;
	int n_fail = 0, cmp_count = 0, i, w, d;
	osrc_row_type r;
	osrc_config #(.CLK_PERIOD_NS(P)) osrc_config_inst (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata, .sclk_pin, .exposures_sel, .burst_en_req, .burst_rate_sel,
		.led_settle_delay, .adc_smp, .fifo_res, .ambient_cancel, .channel1_range, .channel2_range,
		.sample_start, .led_on, .integrate_on, .burst_active, .burst_forced_off);
	// system clock
	initial begin
		forever #10 clk = ~clk;
	end
	// sampling clock sped up to one tick per eight cycles to keep the run short
	initial begin
		#1;
		forever #80 sclk_pin = ~sclk_pin;
	end
	task summarize();
		if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : step
	// strobe dropped and one edge let pass, so back to back calls never collide
	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		step(1);
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		v = reg_rdata;
		reg_rd = 1'b0;
		step(1);
	endtask : rd
	task wait_start();
		int k;
		k = 0;
		step(1);
		while (sample_start !== 1'b1 && k < 12000) begin
			step(1);
			k++;
		end
		chk(k < 12000, 1, "no sample start");
	endtask : wait_start
	// result of the sample shows right after return
	task smp(input logic c, input logic [18:0] v);
		step(1);
		adc_smp = '{1'b1, c, v};
		step(1);
		adc_smp.valid = 1'b0;
	endtask : smp
	task chk_dflt();
		rd(OSRC_ADDR_FRONT, d8);
		chk(d8, OSRC_FRONT_RST, "front reset");
		rd(OSRC_ADDR_RATE, d8);
		chk(d8, OSRC_RATE_RST, "rate reset");
		rd(8'h13, d8);
		chk(d8, 8'h00, "unmapped read");
		chk({ambient_cancel, channel2_range, channel1_range, burst_active}, 6'h20, "reset outputs");
	endtask : chk_dflt
	// main sequence
	initial begin
		step(16);
		rst = 1'b0;
		wr(8'h20, 8'hff);
		chk_dflt();
		for (i = 0; i < 9; i++) begin
			r = ROWS[i];
			exposures_sel = r.expo;
			led_settle_delay = r.settle;
			burst_en_req = r.ben;
			burst_rate_sel = r.brate;
			wr(OSRC_ADDR_FRONT, r.front);
			wr(OSRC_ADDR_RATE, r.rate_wr);
			wait_start();
			wait_start();
			if (r.meas) begin
				step(1);
				w = 0;
				d = -1;
				while (led_on === 1'b1 && w < 300) begin
					if (integrate_on === 1'b1 && d < 0) d = w;
					w++;
					step(1);
				end
				chk(w, (OSRC_TINT_NS[r.front[1:0]] + OSRC_SETTLE_NS[r.settle] + OSRC_PW_EXTRA_NS + P - 1) / P,
					"pulse width");
				chk(d, OSRC_SETTLE_NS[r.settle] / P, "settle");
			end
			rd(OSRC_ADDR_FRONT, d8);
			chk(d8, r.front, "front read");
			rd(OSRC_ADDR_RATE, d8);
			chk(d8, r.rate_wr == r.rate_rd ? r.rate_wr : r.rate_rd, "rate read");
			chk(ambient_cancel, !r.front[7], "cancel");
			chk({channel2_range, channel1_range}, r.front[5:2], "ranges");
			chk(burst_active, r.bact, "burst");
			chk(burst_forced_off, r.ben & !r.bact, "burst off");
		end
		// pairwise average per channel with dark offset
		burst_en_req = 1'b0;
		wr(OSRC_ADDR_FRONT, 8'h40);
		wr(OSRC_ADDR_RATE, 8'h99);
		wait_start();
		wait_start();
		smp(1'b0, 19'h00100);
		chk(fifo_res.valid, 1'b0, "early result");
		smp(1'b1, 19'h7fff0);
		chk(fifo_res.valid, 1'b0, "early result");
		smp(1'b0, 19'h00301);
		chk(fifo_res, {2'b10, 20'h00200 + OSRC_OFFSET_SINGLE}, "avg ch0");
		smp(1'b1, 19'h7fff2);
		chk(fifo_res, {2'b11, 20'h7fff1 + OSRC_OFFSET_SINGLE}, "avg ch1");
		wr(OSRC_ADDR_RATE, 8'h48);
		wait_start();
		wait_start();
		smp(1'b1, 19'h00010);
		chk(fifo_res, {2'b11, 20'h00010 + OSRC_OFFSET_DUAL}, "dual offset");
		wr(OSRC_ADDR_FRONT, 8'h00);
		wait_start();
		wait_start();
		smp(1'b0, 19'h12345);
		chk(fifo_res, {2'b10, 20'h12345}, "no offset");
		// second reset in mid-run
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		chk_dflt();
		summarize();
	end
	// watchdog sized well above the expected run
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		summarize();
	end
endmodule : tb_optical_sample_rate_config
bind osrc_config osrc_config_monitor osrc_config_monitor_inst (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rd, .reg_rdata, .burst_en_req, .adc_smp, .fifo_res, .ambient_cancel, .channel1_range,
	.channel2_range, .sample_start, .led_on, .integrate_on, .burst_active, .burst_forced_off);
`default_nettype wire
